// File: design/sct_defines.svh
/*
  constants for the sleep calibration timer: register offsets, field positions,
  reset values and timing figures.
  assumes inclusion by bare name from the design files.
*/
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH

// register offsets (byte addresses)
`define SCT_OFF_CTRL      8'h00
`define SCT_OFF_PERIOD    8'h04
`define SCT_OFF_COMPARE   8'h08
`define SCT_OFF_COUNT     8'h0c
`define SCT_OFF_STATUS    8'h10
`define SCT_OFF_MASK      8'h14
`define SCT_OFF_ROUTE     8'h18

// control fields
`define SCT_CTRL_EN       0
`define SCT_CTRL_CMP_LE   1
`define SCT_CTRL_IRQ_CMP  2
`define SCT_CTRL_RESYNC   3
`define SCT_CTRL_IRQ_EN   4
`define SCT_CTRL_SWCAP    5

// status / mask fields
`define SCT_ST_TC         0
`define SCT_ST_CMP        1
`define SCT_ST_CAP        2
`define SCT_ST_SEL        3
`define SCT_ST_W          4

// reset values
`define SCT_CTRL_RST      8'h0a
`define SCT_PERIOD_RST    8'hff
`define SCT_COMPARE_RST   8'h00
`define SCT_ROUTE_RST     8'h00

// timing
`define SCT_SYS_HZ        20000000
`define SCT_SLOW_HZ       32000
`define SCT_CAL_US        1000
`define SCT_CAL_TICKS     ((`SCT_SLOW_HZ * `SCT_CAL_US) / 1000000)

`endif

// File: design/sct_edge_sync.sv
/*
  brings the slow oscillator clock and the capture pin into the system clock
  domain and makes one-cycle edge pulses.
  assumes both inputs are asynchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module sct_edge_sync (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   resync_i,
  input  wire logic   slow_clk_i,
  input  wire logic   capture_i,
  sct_tick_if.src     tk
);
  logic [2:0] slow_reg;
  logic [2:0] cap_reg;
  logic       slow_lvl_reg;
  logic       cap_lvl_reg;
  logic       slow_raw_reg;

  // three-stage samplers; only stages 2 and 3 are looked at
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_reg <= 3'h0;
      cap_reg  <= 3'h0;
    end else begin
      slow_reg <= {slow_reg[1:0], slow_clk_i};
      cap_reg  <= {cap_reg[1:0], capture_i};
    end
  end

  // filtered levels: change only when stages 2 and 3 agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_lvl_reg <= 1'b0;
      cap_lvl_reg  <= 1'b0;
      slow_raw_reg <= 1'b0;
    end else begin
      if (slow_reg[2] == slow_reg[1]) slow_lvl_reg <= slow_reg[2];
      if (cap_reg[2] == cap_reg[1]) cap_lvl_reg <= cap_reg[2];
      slow_raw_reg <= slow_reg[1];
    end
  end

  // resync on: edge from agreed level; off: faster but glitch-prone raw edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tk.tick     <= 1'b0;
      tk.cap_rise <= 1'b0;
    end else begin
      tk.tick     <= resync_i ? (slow_reg[2] & slow_reg[1] & ~slow_lvl_reg)
                              : (slow_reg[1] & ~slow_raw_reg);
      tk.cap_rise <= cap_reg[2] & cap_reg[1] & ~cap_lvl_reg;
    end
  end
endmodule : sct_edge_sync
`default_nettype wire

// File: design/sct_pkg.sv
/*
  types of the sleep calibration timer.
  assumes nothing beyond a sv compiler.
*/
package sct_pkg;
  // route choice for the auxiliary outputs: off or one of four row buses
  typedef enum logic [2:0] {
    SCT_ROUTE_OFF  = 3'h0,
    SCT_ROUTE_ROW0 = 3'h1,
    SCT_ROUTE_ROW1 = 3'h3,
    SCT_ROUTE_ROW2 = 3'h2,
    SCT_ROUTE_ROW3 = 3'h6
  } sct_route_t;

  // run state of the counter
  typedef enum logic [1:0] {
    SCT_IDLE   = 2'h0,
    SCT_LOAD   = 2'h1,
    SCT_RUN    = 2'h3
  } sct_state_t;
endpackage : sct_pkg

// File: design/sct_tick_if.sv
/*
  tick carrier between the slow clock conditioner and the timer core.
  assumes one system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface sct_tick_if;
  logic tick;     // one-cycle pulse per slow clock rising edge
  logic cap_rise; // one-cycle pulse per capture rising edge
  modport src (output tick, output cap_rise);
  modport dst (input tick, input cap_rise);
endinterface : sct_tick_if
`default_nettype wire

// File: design/sct_timer.sv
/*
  sleep calibration timer: 8-bit down counter clocked by slow oscillator ticks,
  with period, compare, capture, selectable compare test, interrupt and
  routable terminal count / compare outputs.
  assumes a plain register port with read data one cycle after the strobe and
  a slow clock far below the system clock.
  limitations: the slow clock must stay below about a quarter of the system clock,
  since a tick needs the three-flop sampler to see each level twice; with resync
  off the tick comes a cycle sooner but a glitch on the slow pin can count twice.
  the capture pin is expected to idle low; a pin stuck high hides every later
  pin edge, though the software strobe still works.
*/
// Notes on behaviour
// - eight-bit counter, period any 0 to 255
// - reload at zero and on enable
// - capture rising edge copies count to compare
// - compare event at compare point each period
// - compare test less or less-equal selectable
// - irq source select, separate irq enable
// - terminal count routable or off, always on its own pin
// - compare output routable, always feeds chain
// - optional resync of timer clock to system
// - counts slow ticks over 1 ms
`timescale 1ns/100ps
`default_nettype none
`include "sct_defines.svh"
module sct_timer #(
  parameter int WIDTH = 8,
  parameter int ROWS  = 4
) (
  input  wire logic             CLK_SYS_I,
  input  wire logic             RESETN_I,
  input  wire logic             LOW_POWER_OSC_CLOCK_I,
  input  wire logic             CAPTURE_I,
  input  wire logic [7:0]       ADDR_I,
  input  wire logic [31:0]      WDATA_I,
  input  wire logic             WR_I,
  input  wire logic             RD_I,
  output logic      [31:0]      RDATA_O,
  output logic                  IRQ_O,
  output logic [ROWS-1:0]       ROW_BUS_O,
  output logic                  COMPARE_CHAIN_O,
  output logic                  TERMINAL_COUNT_O
);
  // software-visible registers
  logic [5:0]          ctrl_reg;
  logic [WIDTH-1:0]    period_reg;
  logic [WIDTH-1:0]    compare_reg;
  logic [WIDTH-1:0]    count_reg;
  logic [`SCT_ST_W-1:0] status_reg;
  logic [`SCT_ST_W-1:0] mask_reg;
  logic [5:0]          route_reg;
  // level flags and their delayed copies for edge finding, then the run state and its next value
  logic                tc_reg;
  logic                tc_d_flag;
  logic                cmp_reg;
  logic                cmp_d_reg;
  sct_pkg::sct_state_t state_reg;
  sct_pkg::sct_state_t state_next;
  // decoded strobes and event terms
  logic                wr_ctrl;
  logic                cap_evt;
  logic                cmp_now;
  logic                tc_rise;
  logic                cmp_rise;
  logic [`SCT_ST_W-1:0] evt;
  logic                enabled;

  sct_tick_if tk ();

  // conditioner for the slow clock and capture pin
  sct_edge_sync u_sync (
    .clk_i      (CLK_SYS_I),
    .rst_n_i    (RESETN_I),
    .resync_i   (ctrl_reg[`SCT_CTRL_RESYNC]),
    .slow_clk_i (LOW_POWER_OSC_CLOCK_I),
    .capture_i  (CAPTURE_I),
    .tk         (tk.src)
  );

  // enable and control write decode
  assign enabled = ctrl_reg[`SCT_CTRL_EN];
  assign wr_ctrl = WR_I && (ADDR_I == `SCT_OFF_CTRL);
  // pin edge or software strobe; a pin held high blocks nothing here, and software
  // capture works whatever level the pin sits at
  assign cap_evt = tk.cap_rise
                 | (wr_ctrl & WDATA_I[`SCT_CTRL_SWCAP]);

  // compare test on the live count
  assign cmp_now = ctrl_reg[`SCT_CTRL_CMP_LE] ? (count_reg <= compare_reg)
                                              : (count_reg <  compare_reg);
  // one-cycle edges of the level flags; status wants one set per event, not a
  // stream of sets while the level stays up
  assign tc_rise  = tc_reg & ~tc_d_flag;
  assign cmp_rise = cmp_reg & ~cmp_d_reg;

  // control register; software capture bit is a strobe and never stored
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_reg <= 6'(`SCT_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_reg <= {1'b0, WDATA_I[4:0]};
    end
  end

  // period register; a new period is used from the next reload on
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      period_reg <= WIDTH'(`SCT_PERIOD_RST);
    end else if (WR_I && ADDR_I == `SCT_OFF_PERIOD) begin
      period_reg <= WDATA_I[WIDTH-1:0];
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mask_reg <= '0;
    end else if (WR_I && ADDR_I == `SCT_OFF_MASK) begin
      mask_reg <= WDATA_I[`SCT_ST_W-1:0];
    end
  end

  // output routing; a code outside the table leaves that output off
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      route_reg <= 6'(`SCT_ROUTE_RST);
    end else if (WR_I && ADDR_I == `SCT_OFF_ROUTE) begin
      route_reg <= WDATA_I[5:0];
    end
  end

  // compare register: capture wins over a software write in the same cycle
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      compare_reg <= WIDTH'(`SCT_COMPARE_RST);
    end else if (cap_evt) begin
      compare_reg <= count_reg;
    end else if (WR_I && ADDR_I == `SCT_OFF_COMPARE) begin
      compare_reg <= WDATA_I[WIDTH-1:0];
    end
  end

  // run state: load on the enable edge, then count
  // a disable during the load cycle drops straight back to idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sct_pkg::SCT_IDLE: if (enabled) state_next = sct_pkg::SCT_LOAD;
      sct_pkg::SCT_LOAD: state_next = enabled ? sct_pkg::SCT_RUN : sct_pkg::SCT_IDLE;
      sct_pkg::SCT_RUN:  if (!enabled) state_next = sct_pkg::SCT_IDLE;
      default:           state_next = sct_pkg::SCT_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= sct_pkg::SCT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // counter: reload on enable and at zero, decrement per tick, hold when off
  // holding rather than clearing lets software read the count after stopping,
  // which is how the calibration result is fetched
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      count_reg <= '0;
    end else if (state_reg == sct_pkg::SCT_LOAD) begin
      count_reg <= period_reg;
    end else if (state_reg == sct_pkg::SCT_RUN && tk.tick) begin
      if (count_reg == '0) count_reg <= period_reg;
      else count_reg <= count_reg - 1'b1;
    end
  end

  // terminal count spans one full slow clock: high while the count sits at zero
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tc_reg <= 1'b0;
    end else begin
      tc_reg <= (state_reg == sct_pkg::SCT_RUN) && (count_reg == '0);
    end
  end

  // compare level is gated by run so a stopped timer shows no match
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cmp_reg   <= 1'b0;
      cmp_d_reg <= 1'b0;
    end else begin
      cmp_reg   <= (state_reg == sct_pkg::SCT_RUN) && cmp_now;
      cmp_d_reg <= cmp_reg;
    end
  end

  // event vector; the selected source gets its own bit gated by irq enable
  // capture is an event even with no pin wired, through the software strobe
  always_comb begin
    evt = '0;
    evt[`SCT_ST_TC]  = tc_rise;
    evt[`SCT_ST_CMP] = cmp_rise;
    evt[`SCT_ST_CAP] = cap_evt;
    evt[`SCT_ST_SEL] = ctrl_reg[`SCT_CTRL_IRQ_EN]
                     & (ctrl_reg[`SCT_CTRL_IRQ_CMP] ? cmp_rise : tc_rise);
  end

  // delayed terminal count, used to find its rising edge
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tc_d_flag <= 1'b0;
    end else begin
      tc_d_flag <= tc_reg;
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  // the clear only touches bits written as one, and the event term is ored in
  // last so that a set landing in the clear cycle is never lost
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg
                  & ~((WR_I && ADDR_I == `SCT_OFF_STATUS) ? WDATA_I[`SCT_ST_W-1:0]
                                                          : {`SCT_ST_W{1'b0}}))
                  | evt;
    end
  end

  // level interrupt from unmasked status; registered, so it trails status by
  // one cycle, which software never sees
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status_reg & mask_reg);
    end
  end

  // row bus routing: route_reg[2:0] for terminal count, [5:3] for compare
  // both may land on one row; the row then shows either level
  genvar r;
  generate
    for (r = 0; r < ROWS; r++) begin : g_row
      always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          ROW_BUS_O[r] <= 1'b0;
        end else begin
          ROW_BUS_O[r] <= (route_sel(route_reg[2:0]) == r + 1 && tc_reg)
                        | (route_sel(route_reg[5:3]) == r + 1 && cmp_reg);
        end
      end
    end
  endgenerate

  // maps a gray route code to row number plus one; zero means disabled
  function automatic int route_sel(input logic [2:0] code);
    case (sct_pkg::sct_route_t'(code))
      sct_pkg::SCT_ROUTE_ROW0: route_sel = 1;
      sct_pkg::SCT_ROUTE_ROW1: route_sel = 2;
      sct_pkg::SCT_ROUTE_ROW2: route_sel = 3;
      sct_pkg::SCT_ROUTE_ROW3: route_sel = 4;
      default:                 route_sel = 0;
    endcase
  endfunction : route_sel

  // chain output to the next block, independent of routing and interrupts
  // terminal count pin carries the plain level, not the routed copy
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      COMPARE_CHAIN_O  <= 1'b0;
      TERMINAL_COUNT_O <= 1'b0;
    end else begin
      COMPARE_CHAIN_O  <= cmp_reg;
      TERMINAL_COUNT_O <= tc_reg;
    end
  end

  // read port: data stand in the cycle after the strobe only
  // zero between answers keeps a shared read bus free of stale values
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 32'h0;
    end else if (RD_I) begin
      case (ADDR_I)
        `SCT_OFF_CTRL:    RDATA_O <= {26'h0, ctrl_reg};
        `SCT_OFF_PERIOD:  RDATA_O <= {{(32-WIDTH){1'b0}}, period_reg};
        `SCT_OFF_COMPARE: RDATA_O <= {{(32-WIDTH){1'b0}}, compare_reg};
        `SCT_OFF_COUNT:   RDATA_O <= {{(32-WIDTH){1'b0}}, count_reg};
        `SCT_OFF_STATUS:  RDATA_O <= {{(32-`SCT_ST_W){1'b0}}, status_reg};
        `SCT_OFF_MASK:    RDATA_O <= {{(32-`SCT_ST_W){1'b0}}, mask_reg};
        `SCT_OFF_ROUTE:   RDATA_O <= {26'h0, route_reg};
        default:          RDATA_O <= 32'h0;
      endcase
    end else begin
      RDATA_O <= 32'h0;
    end
  end

endmodule : sct_timer
`default_nettype wire

// File: test/sct_timer_assertions.sv
/*
  port checker of the sleep calibration timer, with shadow copies of written registers.
  assumes a bind into sct_timer and its single system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sct_defines.svh"
module sct_timer_assertions #(
  parameter int WIDTH = 8,
  parameter int ROWS  = 4
) (
  input  wire logic            CLK_SYS_I,
  input  wire logic            RESETN_I,
  input  wire logic [7:0]      ADDR_I,
  input  wire logic [31:0]     WDATA_I,
  input  wire logic            WR_I,
  input  wire logic            RD_I,
  input  wire logic [31:0]     RDATA_O,
  input  wire logic            IRQ_O,
  input  wire logic [ROWS-1:0] ROW_BUS_O,
  input  wire logic            COMPARE_CHAIN_O,
  input  wire logic            TERMINAL_COUNT_O
);
  logic [7:0] ctrl_reg;
  logic [7:0] period_reg;
  logic [7:0] mask_reg;
  logic [7:0] route_reg;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  // shadows follow software writes, so read-back and routing can be judged
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_reg   <= `SCT_CTRL_RST;
      period_reg <= `SCT_PERIOD_RST;
      mask_reg   <= 8'h00;
      route_reg  <= `SCT_ROUTE_RST;
    end else if (WR_I) begin
      case (ADDR_I)
        `SCT_OFF_CTRL:   ctrl_reg   <= WDATA_I[7:0];
        `SCT_OFF_PERIOD: period_reg <= WDATA_I[7:0];
        `SCT_OFF_MASK:   mask_reg   <= {4'h0, WDATA_I[3:0]};
        `SCT_OFF_ROUTE:  route_reg  <= {2'h0, WDATA_I[5:0]};
        default: ;
      endcase
    end
  end
  chk_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_rd_unmapped: assert property ($past(RD_I) && $past(ADDR_I) > 8'h18 |-> RDATA_O == 32'h0)
    else $error("unmapped read not zero");
  chk_period_back: assert property ($past(RD_I) && $past(ADDR_I) == `SCT_OFF_PERIOD
      |-> RDATA_O == {24'h0, period_reg})
    else $error("period read-back wrong");
  chk_ctrl_back: assert property ($past(RD_I) && $past(ADDR_I) == `SCT_OFF_CTRL
      |-> RDATA_O == {27'h0, ctrl_reg[4:0]})
    else $error("control read-back wrong");
  // mask takes effect at the write edge, irq is one register later
  chk_irq_masked: assert property ((mask_reg == 8'h00)[*2] |-> !IRQ_O)
    else $error("irq high with all sources masked");
  chk_tc_full: assert property ($rose(TERMINAL_COUNT_O) |=> TERMINAL_COUNT_O)
    else $error("terminal count shorter than a timer clock");
  chk_tc_idle: assert property ((!ctrl_reg[0])[*4] |-> !TERMINAL_COUNT_O)
    else $error("terminal count while disabled");
  chk_row_off: assert property ((route_reg == 8'h00)[*2] |-> ROW_BUS_O == '0)
    else $error("row bus driven with routing off");
  chk_row_cmp: assert property ((route_reg == 8'h18)[*2] |-> ROW_BUS_O[1] == COMPARE_CHAIN_O)
    else $error("row1 does not follow compare");
  cov_tc_irq: cover property (TERMINAL_COUNT_O && IRQ_O);
  cov_both_rows: cover property (ROW_BUS_O[1:0] == 2'h3);
  cov_cmp_rise: cover property ($rose(COMPARE_CHAIN_O));
endmodule : sct_timer_assertions
bind sct_timer sct_timer_assertions #(.WIDTH(WIDTH), .ROWS(ROWS)) chk_u (.CLK_SYS_I, .RESETN_I,
  .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .IRQ_O, .ROW_BUS_O, .COMPARE_CHAIN_O,
  .TERMINAL_COUNT_O);
`default_nettype wire

// File: test/tb_sleep_calibration_timer.sv
/*
  self-checking bench of the sleep calibration timer.
  assumes the slow clock is made here by hand, ticks far apart against the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sct_defines.svh"
module tb_sleep_calibration_timer;
  logic        clk;
  logic        rst_n;
  logic        osc;
  logic        cap;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  logic [3:0]  row;
  logic        chain;
  logic        tc;
  int          fails;
  int          checks_done;
  localparam logic [31:0] ALL_M = 32'hffffffff;
  sct_timer dut_u (.CLK_SYS_I(clk), .RESETN_I(rst_n), .LOW_POWER_OSC_CLOCK_I(osc),
    .CAPTURE_I(cap), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .IRQ_O(irq), .ROW_BUS_O(row), .COMPARE_CHAIN_O(chain),
    .TERMINAL_COUNT_O(tc));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe, so look just past that edge
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e & m, rdata & m);
  endtask : rd_reg
  // h high and h low cycles per slow tick; sync needs about six cycles
  task automatic tick(input int n, input int h);
    repeat (n) begin
      osc <= 1'b1;
      repeat (h) @(posedge clk);
      osc <= 1'b0;
      repeat (h) @(posedge clk);
    end
  endtask : tick
  task automatic t_reset();
    rd_reg(`SCT_OFF_CTRL, 32'h0000000a, ALL_M);
    rd_reg(`SCT_OFF_PERIOD, 32'h000000ff, ALL_M);
    rd_reg(`SCT_OFF_COMPARE, 32'h00000000, ALL_M);
    rd_reg(`SCT_OFF_ROUTE, 32'h00000000, ALL_M);
    rd_reg(8'h1c, 32'h00000000, ALL_M);
  endtask : t_reset
  // 32 ticks at about 32 kHz inside 1 ms leave 255 - 32 in the counter
  task automatic t_calib();
    wr_reg(`SCT_OFF_PERIOD, 32'h000000ff);
    wr_reg(`SCT_OFF_CTRL, 32'h0000000b);
    repeat (4) @(posedge clk);
    rd_reg(`SCT_OFF_COUNT, 32'h000000ff, ALL_M);
    tick(32, 312);
    wr_reg(`SCT_OFF_CTRL, 32'h0000000a);
    rd_reg(`SCT_OFF_COUNT, 32'h000000df, ALL_M);
    tick(3, 8);
    rd_reg(`SCT_OFF_COUNT, 32'h000000df, ALL_M);
  endtask : t_calib
  task automatic t_wrap();
    wr_reg(`SCT_OFF_PERIOD, 32'h00000002);
    wr_reg(`SCT_OFF_MASK, 32'h00000001);
    wr_reg(`SCT_OFF_STATUS, 32'h0000000f);
    wr_reg(`SCT_OFF_CTRL, 32'h0000000b);
    tick(2, 8);
    chk("tc", 32'h1, 32'(tc));
    chk("irq", 32'h1, 32'(irq));
    tick(1, 8);
    rd_reg(`SCT_OFF_COUNT, 32'h00000002, ALL_M);
    chk("tc", 32'h0, 32'(tc));
    wr_reg(`SCT_OFF_STATUS, 32'h00000001);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, 32'(irq));
    wr_reg(`SCT_OFF_MASK, 32'h00000008);
    wr_reg(`SCT_OFF_CTRL, 32'h0000001b);
    tick(2, 8);
    chk("irq", 32'h1, 32'(irq));
    rd_reg(`SCT_OFF_STATUS, 32'h00000009, 32'h0000000d);
  endtask : t_wrap
  task automatic t_compare();
    logic [2:0] codes [5];
    codes = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6};
    wr_reg(`SCT_OFF_CTRL, 32'h0000000a);
    wr_reg(`SCT_OFF_PERIOD, 32'h00000004);
    wr_reg(`SCT_OFF_COMPARE, 32'h00000002);
    wr_reg(`SCT_OFF_ROUTE, 32'h00000019);
    wr_reg(`SCT_OFF_STATUS, 32'h0000000f);
    wr_reg(`SCT_OFF_CTRL, 32'h0000001f);
    tick(1, 8);
    chk("irq", 32'h0, 32'(irq));
    tick(1, 8);
    chk("chain", 32'h1, 32'(chain));
    chk("irq", 32'h1, 32'(irq));
    chk("row", 32'h2, 32'(row));
    wr_reg(`SCT_OFF_CTRL, 32'h0000001d);
    repeat (3) @(posedge clk);
    chk("chain", 32'h0, 32'(chain));
    tick(2, 8);
    chk("row", 32'h3, 32'(row));
    // parked at zero, tc and compare both high while each route code is tried
    for (int i = 0; i < 10; i++) begin
      wr_reg(`SCT_OFF_ROUTE, (i % 2) ? {26'h0, codes[i / 2], 3'h0} : {29'h0, codes[i / 2]});
      repeat (3) @(posedge clk);
      chk("row", (i < 2) ? 32'h0 : 32'h1 << (i / 2 - 1), 32'(row));
      chk("chain", 32'h1, 32'(chain));
    end
  endtask : t_compare
  task automatic t_capture();
    tick(2, 8);
    cap <= 1'b1;
    repeat (10) @(posedge clk);
    cap <= 1'b0;
    repeat (10) @(posedge clk);
    rd_reg(`SCT_OFF_COMPARE, 32'h00000003, ALL_M);
    tick(1, 8);
    wr_reg(`SCT_OFF_CTRL, 32'h0000003d);
    rd_reg(`SCT_OFF_COMPARE, 32'h00000002, ALL_M);
    rd_reg(`SCT_OFF_CTRL, 32'h0000001d, ALL_M);
    // resync off: raw edge path still counts one per slow tick
    wr_reg(`SCT_OFF_CTRL, 32'h00000005);
    tick(1, 8);
    rd_reg(`SCT_OFF_COUNT, 32'h00000001, ALL_M);
  endtask : t_capture
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // the calibration alone is about 20000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    osc   = 1'b0;
    cap   = 1'b0;
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_calib();
    t_wrap();
    t_compare();
    t_capture();
    results();
  end
endmodule : tb_sleep_calibration_timer
`default_nettype wire
